//--- inc/rhsc_pkg.sv
// Package of the root hub status and command block.
// Assumes a single clock domain and a plain register port.
package rhsc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] RHSC_STATUS_OFS = 8'h50;
  localparam logic [7:0] RHSC_CTRL_OFS   = 8'h54;
  localparam logic [7:0] RHSC_IRQ_ST_OFS = 8'h58;
  localparam logic [7:0] RHSC_IRQ_MK_OFS = 8'h5c;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int RHSC_PWR_OFF_BIT  = 0;
  localparam int RHSC_OC_BIT       = 1;
  localparam int RHSC_WAKE_EN_BIT  = 15;
  localparam int RHSC_PWR_ON_BIT   = 16;
  localparam int RHSC_OC_CHG_BIT   = 17;
  localparam int RHSC_WAKE_CLR_BIT = 31;

  // Control register fields
  localparam int RHSC_SCHEME_BIT   = 0;
  localparam int RHSC_PERPORT_BIT  = 1;
  localparam int RHSC_MASK_LSB     = 16;

  // Interrupt status fields
  localparam int RHSC_IRQ_OC_CHG_BIT = 0;
  localparam int RHSC_IRQ_RESUME_BIT = 1;
  localparam int RHSC_IRQ_W          = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic        RHSC_RWE_RST    = 1'b0;
  localparam logic        RHSC_OC_CHG_RST = 1'b0;
  localparam logic [31:0] RHSC_CTRL_RST   = 32'h0000_0000;
  localparam logic [1:0]  RHSC_IRQ_RST    = 2'h0;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rhsc_bus_s;

  typedef enum logic [1:0] {
    RHSC_OPER,
    RHSC_SUSPEND,
    RHSC_RESUME
  } rhsc_state_e;

endpackage : rhsc_pkg

//--- logic/rhsc_sticky.sv
// Sticky flag bank with write-one-to-clear.
// Assumes set pulses and clear strobes share mclk_i.
`timescale 1ns/100ps
module rhsc_sticky #(
  parameter int W = 2
) (
  input  wire logic         mclk_i,
  input  wire logic         rstn_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  output logic      [W-1:0] flag_o
);

  // ****************************************
  // Flags, set wins over clear
  // ****************************************
  logic [W-1:0] flag_next;

  assign flag_next = set_i | (flag_o & ~clr_i);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_o <= '0;
    end else if (ce_i) begin
      flag_o <= flag_next;
    end
  end

endmodule : rhsc_sticky

//--- logic/rhsc_power.sv
// Per-port power state under global and per-port commands.
// Assumes one-cycle command strobes on mclk_i.
`timescale 1ns/100ps
module rhsc_power #(
  parameter int NPORT = 1
) (
  input  wire logic             mclk_i,
  input  wire logic             rstn_i,
  input  wire logic             ce_i,
  input  wire logic             scheme_i,
  input  wire logic [NPORT-1:0] mask_i,
  input  wire logic             glob_on_i,
  input  wire logic             glob_off_i,
  input  wire logic [NPORT-1:0] port_on_i,
  input  wire logic [NPORT-1:0] port_off_i,
  output logic      [NPORT-1:0] power_o
);

  // ****************************************
  // One power bit per port
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : g_port
      wire logic glob_ok;
      wire logic on_hit;
      wire logic off_hit;
      assign glob_ok = !scheme_i || !mask_i[g];
      assign on_hit  = (glob_on_i && glob_ok)
                       || (port_on_i[g] && scheme_i && mask_i[g]);
      assign off_hit = (glob_off_i && glob_ok)
                       || (port_off_i[g] && scheme_i && mask_i[g]);
      always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          power_o[g] <= 1'b0;
        end else if (ce_i) begin
          if (on_hit) begin
            power_o[g] <= 1'b1;
          end else if (off_hit) begin
            power_o[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule : rhsc_power

//--- logic/rhsc_top.sv
// Root hub status and command register with power and wakeup logic.
// Assumes a plain register port and synchronous pin inputs on mclk_i.
//
// Behaviour
// - A one written to the wakeup clear command clears the wakeup enable, unless the same write also sets it.
// - Any change of the overcurrent indicator sets its change flag.
// - The overcurrent change flag clears on a written one, not on a zero.
// - Global power-on in global mode powers every port.
// - Global power-on in per-port mode powers only unmasked ports.
// - Global power-off in global mode unpowers every port, unless the same write also carries global power-on.
// - Global power-off in per-port mode unpowers only unmasked ports, unless the same write also carries global power-on.
// - With wakeup enabled an attach change takes suspend to resume.
// - A one written to the wakeup enable sets it; a zero does nothing.
// - The overcurrent indicator follows the global overcurrent input.
// - With per-port overcurrent the indicator stays at zero.
// - In per-port mode masked ports obey only per-port commands; in global mode every port obeys only global commands.
`timescale 1ns/100ps
module rhsc_top #(
  parameter int NPORT = 1
) (
  input  wire logic             mclk_i,
  input  wire logic             rstn_i,
  input  wire logic             ce_i,
  input  wire logic [7:0]       addr_i,
  input  wire logic [31:0]      wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic      [31:0]      rdata_o,
  input  wire logic             overcurrent_i,
  input  wire logic             attach_change_i,
  input  wire logic             suspend_req_i,
  input  wire logic             resume_done_i,
  input  wire logic [NPORT-1:0] port_on_i,
  input  wire logic [NPORT-1:0] port_off_i,
  output logic      [NPORT-1:0] port_power_state_o,
  output logic      [1:0]       hc_state_o,
  output logic                  irq_o
);

  // ****************************************
  // Bus decode
  // ****************************************
  rhsc_pkg::rhsc_bus_s bus;
  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  // ****************************************
  // Register select
  // ****************************************
  function automatic logic [3:0] reg_sel(input logic [7:0] a);
    reg_sel = {hit(a, rhsc_pkg::RHSC_IRQ_MK_OFS),
               hit(a, rhsc_pkg::RHSC_IRQ_ST_OFS),
               hit(a, rhsc_pkg::RHSC_CTRL_OFS),
               hit(a, rhsc_pkg::RHSC_STATUS_OFS)};
  endfunction : reg_sel

  wire logic [3:0] sel;
  wire logic [3:0] wr_sel;
  wire logic       wr_status;
  wire logic       wr_ctrl;
  wire logic       wr_irq_st;
  wire logic       wr_irq_mk;
  assign sel       = reg_sel(bus.addr);
  assign wr_sel    = bus.wr ? sel : 4'h0;
  assign wr_status = wr_sel[0];
  assign wr_ctrl   = wr_sel[1];
  assign wr_irq_st = wr_sel[2];
  assign wr_irq_mk = wr_sel[3];

  // ****************************************
  // Command strobes
  // ****************************************
  wire logic glob_on;
  wire logic glob_off;
  wire logic rwe_set;
  wire logic rwe_clr;
  wire logic ovc_chg_clr;
  assign glob_on     = wr_status
                       && bus.wdata[rhsc_pkg::RHSC_PWR_ON_BIT];
  assign glob_off    = wr_status
                       && bus.wdata[rhsc_pkg::RHSC_PWR_OFF_BIT];
  assign rwe_set     = wr_status
                       && bus.wdata[rhsc_pkg::RHSC_WAKE_EN_BIT];
  assign rwe_clr     = wr_status
                       && bus.wdata[rhsc_pkg::RHSC_WAKE_CLR_BIT];
  assign ovc_chg_clr = wr_status
                       && bus.wdata[rhsc_pkg::RHSC_OC_CHG_BIT];

  // ****************************************
  // Control register
  // ****************************************
  logic             scheme_reg;
  logic             perport_reg;
  logic [NPORT-1:0] mask_reg;
  wire logic             scheme;
  wire logic             perport_oc;
  wire logic [NPORT-1:0] mask;
  wire logic             scheme_next;
  wire logic             perport_next;
  wire logic [NPORT-1:0] mask_next;
  assign scheme_next  = wr_ctrl ? bus.wdata[rhsc_pkg::RHSC_SCHEME_BIT]
                                : scheme_reg;
  assign perport_next = wr_ctrl ? bus.wdata[rhsc_pkg::RHSC_PERPORT_BIT]
                                : perport_reg;
  assign mask_next    = wr_ctrl ? bus.wdata[rhsc_pkg::RHSC_MASK_LSB +: NPORT]
                                : mask_reg;
  assign scheme     = scheme_reg;
  assign perport_oc = perport_reg;
  assign mask       = mask_reg;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scheme_reg  <= rhsc_pkg::RHSC_CTRL_RST[rhsc_pkg::RHSC_SCHEME_BIT];
      perport_reg <= rhsc_pkg::RHSC_CTRL_RST[rhsc_pkg::RHSC_PERPORT_BIT];
      mask_reg    <= rhsc_pkg::RHSC_CTRL_RST[rhsc_pkg::RHSC_MASK_LSB +: NPORT];
    end else if (ce_i) begin
      scheme_reg  <= scheme_next;
      perport_reg <= perport_next;
      mask_reg    <= mask_next;
    end
  end

  // ****************************************
  // Control field view
  // ****************************************
  wire logic [31:0] ctrl_view;
  assign ctrl_view = {15'h0000, mask[0], 14'h0000, perport_oc, scheme};

  // ****************************************
  // Overcurrent and change flag
  // ****************************************
  logic ovc_reg;
  logic ovc_chg_reg;
  wire logic ovc_next;
  wire logic ovc_event;
  wire logic ovc_chg_next;
  assign ovc_next     = overcurrent_i && !perport_oc;
  assign ovc_event    = ovc_next != ovc_reg;
  assign ovc_chg_next = ovc_event || (ovc_chg_reg && !ovc_chg_clr);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ovc_reg <= 1'b0;
    end else if (ce_i) begin
      ovc_reg <= ovc_next;
    end
  end

  // ****************************************
  // Overcurrent change flag
  // ****************************************
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ovc_chg_reg <= rhsc_pkg::RHSC_OC_CHG_RST;
    end else if (ce_i) begin
      ovc_chg_reg <= ovc_chg_next;
    end
  end

  // ****************************************
  // Remote wakeup enable
  // ****************************************
  logic rwe_reg;
  wire logic rwe_next;
  assign rwe_next = rwe_set ? 1'b1 : (rwe_clr ? 1'b0 : rwe_reg);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rwe_reg <= rhsc_pkg::RHSC_RWE_RST;
    end else if (ce_i) begin
      rwe_reg <= rwe_next;
    end
  end

  // ****************************************
  // Controller state
  // ****************************************
  rhsc_pkg::rhsc_state_e state_reg;
  rhsc_pkg::rhsc_state_e state_next;
  wire logic in_suspend;
  wire logic wake;
  assign in_suspend = (state_reg == rhsc_pkg::RHSC_SUSPEND);
  assign wake       = in_suspend && attach_change_i && rwe_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      rhsc_pkg::RHSC_OPER: begin
        if (suspend_req_i) begin
          state_next = rhsc_pkg::RHSC_SUSPEND;
        end
      end
      rhsc_pkg::RHSC_SUSPEND: begin
        if (wake) begin
          state_next = rhsc_pkg::RHSC_RESUME;
        end
      end
      rhsc_pkg::RHSC_RESUME: begin
        if (resume_done_i) begin
          state_next = rhsc_pkg::RHSC_OPER;
        end
      end
      default: begin
        state_next = rhsc_pkg::RHSC_OPER;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= rhsc_pkg::RHSC_OPER;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  assign hc_state_o = state_reg;

  // ****************************************
  // Port power
  // ****************************************
  rhsc_power #(
    .NPORT (NPORT)
  ) u_power (
    .mclk_i     (mclk_i),
    .rstn_i     (rstn_i),
    .ce_i       (ce_i),
    .scheme_i   (scheme),
    .mask_i     (mask),
    .glob_on_i  (glob_on),
    .glob_off_i (glob_off),
    .port_on_i  (port_on_i),
    .port_off_i (port_off_i),
    .power_o    (port_power_state_o)
  );

  // ****************************************
  // Interrupts
  // ****************************************
  wire logic [rhsc_pkg::RHSC_IRQ_W-1:0] irq_set;
  wire logic [rhsc_pkg::RHSC_IRQ_W-1:0] irq_clr;
  logic      [rhsc_pkg::RHSC_IRQ_W-1:0] irq_st;
  logic      [rhsc_pkg::RHSC_IRQ_W-1:0] irq_mk_reg;
  assign irq_set = {wake, ovc_event};
  assign irq_clr = wr_irq_st ? bus.wdata[rhsc_pkg::RHSC_IRQ_W-1:0] : '0;

  rhsc_sticky #(
    .W (rhsc_pkg::RHSC_IRQ_W)
  ) u_sticky (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .ce_i   (ce_i),
    .set_i  (irq_set),
    .clr_i  (irq_clr),
    .flag_o (irq_st)
  );

  // ****************************************
  // Interrupt mask
  // ****************************************
  wire logic [rhsc_pkg::RHSC_IRQ_W-1:0] irq_mk_next;
  wire logic [rhsc_pkg::RHSC_IRQ_W-1:0] irq_pend;
  assign irq_mk_next = wr_irq_mk ? bus.wdata[rhsc_pkg::RHSC_IRQ_W-1:0]
                                 : irq_mk_reg;
  assign irq_pend    = irq_st & irq_mk_reg;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_mk_reg <= rhsc_pkg::RHSC_IRQ_RST;
    end else if (ce_i) begin
      irq_mk_reg <= irq_mk_next;
    end
  end

  assign irq_o = |irq_pend;

  // ****************************************
  // Status field views
  // ****************************************
  wire logic pwr_off_view;
  wire logic oc_view;
  wire logic wake_en_view;
  wire logic pwr_on_view;
  wire logic oc_chg_view;
  wire logic wake_clr_view;
  assign pwr_off_view  = 1'b0;
  assign oc_view       = ovc_reg;
  assign wake_en_view  = rwe_reg;
  assign pwr_on_view   = 1'b0;
  assign oc_chg_view   = ovc_chg_reg;
  assign wake_clr_view = 1'b0;

  // ****************************************
  // Read back
  // ****************************************
  wire logic [31:0] status_view;
  wire logic [31:0] irq_st_view;
  wire logic [31:0] irq_mk_view;
  wire logic [31:0] rd_mux;
  wire logic [31:0] rdata_next;
  assign status_view = {wake_clr_view, 13'h0000, oc_chg_view, pwr_on_view,
                        wake_en_view, 13'h0000, oc_view, pwr_off_view};
  assign irq_st_view = {30'h0, irq_st};
  assign irq_mk_view = {30'h0, irq_mk_reg};
  assign rd_mux      = ({32{sel[0]}} & status_view)
                     | ({32{sel[1]}} & ctrl_view)
                     | ({32{sel[2]}} & irq_st_view)
                     | ({32{sel[3]}} & irq_mk_view);
  assign rdata_next  = bus.rd ? rd_mux : 32'h0000_0000;

  // ****************************************
  // Read data register
  // ****************************************
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      rdata_o <= rdata_next;
    end
  end

endmodule : rhsc_top

//--- sim/rhsc_usb_dev.sv
// Device model on the root hub port: attach and fault events.
// Assumes the bench commands plug and short state on mclk_i.
`timescale 1ns/100ps
module rhsc_usb_dev (
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  input  wire logic plug_i,
  input  wire logic short_i,
  output logic      attach_change_o,
  output logic      overcurrent_o
);
  logic plug_reg;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      plug_reg        <= 1'b0;
      attach_change_o <= 1'b0;
      overcurrent_o   <= 1'b0;
    end else begin
      plug_reg        <= plug_i;
      attach_change_o <= plug_i != plug_reg;
      overcurrent_o   <= short_i;
    end
  end
endmodule : rhsc_usb_dev

//--- sim/rhsc_monitor.sv
// Checker on the ports of the root hub status block.
// Assumes ce_i held high and one downstream port.
`timescale 1ns/100ps
module rhsc_monitor #(
  parameter int NPORT = 1
) (
  input wire logic             mclk_i,
  input wire logic             rstn_i,
  input wire logic [7:0]       addr_i,
  input wire logic [31:0]      wdata_i,
  input wire logic             wr_i,
  input wire logic             rd_i,
  input wire logic [31:0]      rdata_o,
  input wire logic             attach_change_i,
  input wire logic [NPORT-1:0] port_on_i,
  input wire logic [NPORT-1:0] port_off_i,
  input wire logic [NPORT-1:0] port_power_state_o,
  input wire logic [1:0]       hc_state_o
);
  logic [31:0] ctl_reg;
  logic        wk_reg;
  wire         st_wr = wr_i && addr_i == 8'h50;
  wire         st_rd = rd_i && addr_i == 8'h50;

  // Shadow of control and wakeup enable
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctl_reg <= 32'h0;
      wk_reg  <= 1'b0;
    end else begin
      if (wr_i && addr_i == 8'h54) ctl_reg <= wdata_i;
      if (st_wr && (wdata_i[15] || wdata_i[31])) wk_reg <= wdata_i[15];
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  sequence wake_req;
    hc_state_o == 2'h1 && attach_change_i && wk_reg;
  endsequence

  rsvd_zero_a: assert property (
    $past(st_rd) |-> rdata_o[31:18] == 14'h0 && !rdata_o[16]
      && rdata_o[14:2] == 13'h0 && !rdata_o[0])
    else $error("status reads nonzero constant bits");
  wk_read_a: assert property (
    $past(st_rd) |-> rdata_o[15] == wk_reg)
    else $error("wakeup enable reads wrong");
  oc_perport_a: assert property (
    $past(st_rd) && ctl_reg[1] |-> !rdata_o[1])
    else $error("overcurrent flag set in per-port mode");
  glob_on_a: assert property (
    st_wr && wdata_i[16] && !ctl_reg[0] |=> &port_power_state_o)
    else $error("global power on missed");
  glob_off_a: assert property (
    st_wr && wdata_i[0] && !wdata_i[16] && !ctl_reg[0]
      |=> port_power_state_o == '0)
    else $error("global power off missed");
  mask_hold_a: assert property (
    st_wr && (wdata_i[16] || wdata_i[0]) && ctl_reg[0] && ctl_reg[16]
      && port_on_i == '0 && port_off_i == '0
      |=> $stable(port_power_state_o))
    else $error("masked port changed by global command");
  wake_go_a: assert property (
    wake_req |=> hc_state_o == 2'h2)
    else $error("wakeup did not resume");
  no_wake_a: assert property (
    hc_state_o == 2'h1 && !wk_reg |=> hc_state_o != 2'h2)
    else $error("resume without wakeup enable");
endmodule : rhsc_monitor

bind rhsc_top rhsc_monitor #(.NPORT(NPORT)) u_mon (.mclk_i, .rstn_i,
  .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .attach_change_i,
  .port_on_i, .port_off_i, .port_power_state_o, .hc_state_o);

//--- sim/tb_root_hub_status_control.sv
// Testbench of the root hub status block with one port.
// Assumes the device model and the bound checker.
`timescale 1ns/100ps
module tb_root_hub_status_control;
  logic        mclk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        ce_i = 1'b1;
  logic [7:0]  addr_i = 8'h0;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        suspend_req_i = 1'b0;
  logic        resume_done_i = 1'b0;
  logic [0:0]  port_on_i = 1'h0;
  logic [0:0]  port_off_i = 1'h0;
  logic        plug = 1'b0;
  logic        short = 1'b0;
  wire  [31:0] rdata_o;
  wire  [0:0]  port_power_state_o;
  wire  [1:0]  hc_state_o;
  wire         irq_o;
  wire         overcurrent_i;
  wire         attach_change_i;
  int          n_errors = 0;
  int          tests_run = 0;

  always #50 mclk_i = ~mclk_i;

  rhsc_top #(.NPORT(1)) dut (.mclk_i, .rstn_i, .ce_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .overcurrent_i, .attach_change_i,
    .suspend_req_i, .resume_done_i, .port_on_i, .port_off_i,
    .port_power_state_o, .hc_state_o, .irq_o);
  rhsc_usb_dev u_dev (.mclk_i, .rstn_i, .plug_i(plug), .short_i(short),
    .attach_change_o(attach_change_i), .overcurrent_o(overcurrent_i));

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    check(rdata_o, exp);
  endtask : rd

  task automatic pp(input logic e);
    check({31'h0, port_power_state_o}, {31'h0, e});
  endtask : pp

  task automatic hq(input logic [1:0] s, input logic q);
    check({29'h0, hc_state_o, irq_o}, {29'h0, s, q});
  endtask : hq

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_bits;
    rd(8'h50, 32'h0);
    rd(8'h60, 32'h0);
    wr(8'h50, 32'h8000);
    rd(8'h50, 32'h8000);
    wr(8'h50, 32'h0);
    rd(8'h50, 32'h8000);
    wr(8'h50, 32'h8000_0000);
    rd(8'h50, 32'h0);
  endtask : t_bits

  task automatic t_power;
    wr(8'h50, 32'h1_0000);
    pp(1'b1);
    wr(8'h50, 32'h1);
    pp(1'b0);
    wr(8'h54, 32'h1_0001);
    wr(8'h50, 32'h1_0000);
    pp(1'b0);
    @(posedge mclk_i);
    port_on_i <= 1'h1;
    @(posedge mclk_i);
    port_on_i <= 1'h0;
    #1;
    pp(1'b1);
    wr(8'h50, 32'h1);
    pp(1'b1);
    @(posedge mclk_i);
    port_off_i <= 1'h1;
    @(posedge mclk_i);
    port_off_i <= 1'h0;
    #1;
    pp(1'b0);
    wr(8'h54, 32'h1);
    wr(8'h50, 32'h1_0000);
    pp(1'b1);
    wr(8'h50, 32'h1);
    pp(1'b0);
    wr(8'h54, 32'h0);
  endtask : t_power

  task automatic t_ocur;
    wr(8'h5c, 32'h1);
    short <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rd(8'h50, 32'h2_0002);
    hq(2'h0, 1'b1);
    wr(8'h50, 32'h0);
    rd(8'h50, 32'h2_0002);
    wr(8'h50, 32'h2_0000);
    rd(8'h50, 32'h2);
    short <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rd(8'h50, 32'h2_0000);
    wr(8'h50, 32'h2_0000);
    wr(8'h58, 32'h1);
    hq(2'h0, 1'b0);
    wr(8'h54, 32'h2);
    short <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rd(8'h50, 32'h0);
    short <= 1'b0;
    wr(8'h54, 32'h0);
  endtask : t_ocur

  task automatic t_resume;
    wr(8'h5c, 32'h2);
    suspend_req_i <= 1'b1;
    @(posedge mclk_i);
    suspend_req_i <= 1'b0;
    plug <= 1'b1;
    repeat (4) @(posedge mclk_i);
    #1;
    hq(2'h1, 1'b0);
    wr(8'h50, 32'h8000);
    plug <= 1'b0;
    repeat (4) @(posedge mclk_i);
    #1;
    hq(2'h2, 1'b1);
    resume_done_i <= 1'b1;
    @(posedge mclk_i);
    resume_done_i <= 1'b0;
    wr(8'h58, 32'h2);
    hq(2'h0, 1'b0);
  endtask : t_resume

  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (10) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_bits;
    t_power;
    t_ocur;
    t_resume;
    summarize;
  end

  initial begin
    #200000;
    n_errors++;
    summarize;
  end
endmodule : tb_root_hub_status_control
